// ---- design/bltc_pkg.sv ----
// Constants, register indices and types for the block-transfer control core
// Assumes one memory-clock domain shared with the host index port
package bltc_pkg;

  // Data widths
  localparam int unsigned IO_W = 8;
  localparam int unsigned PIX_W = 16;
  localparam int unsigned CNT_W = 16;

  // Register indices behind the data port
  localparam logic [7:0] IDX_TRANSFER_MODE = 8'h30;
  localparam logic [7:0] IDX_CTRL_STATUS = 8'h31;
  localparam logic [7:0] IDX_ROP_SELECT = 8'h32;
  localparam logic [7:0] IDX_TCOLOR_LOW = 8'h34;
  localparam logic [7:0] IDX_TCOLOR_HIGH = 8'h35;
  localparam logic [7:0] IDX_TMASK_LOW = 8'h38;
  localparam logic [7:0] IDX_TMASK_HIGH = 8'h39;

  // Control/status field positions
  localparam int unsigned CTRL_BUSY_BIT = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam int unsigned CTRL_RESET_BIT = 2;
  localparam int unsigned CTRL_PROGRESS_BIT = 3;

  // Transfer mode field positions
  localparam int unsigned MODE_TCMP_EN_BIT = 3;
  localparam int unsigned MODE_TCMP_WIDE_BIT = 4;
  localparam int unsigned MODE_PATTERN_BIT = 6;

  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Raster-operation codes
  localparam logic [7:0] ROP_ZERO = 8'h00;
  localparam logic [7:0] ROP_NS_AND_ND = 8'h90;
  localparam logic [7:0] ROP_NS_AND_D = 8'h50;
  localparam logic [7:0] ROP_NOT_S = 8'hd0;
  localparam logic [7:0] ROP_S_AND_ND = 8'h09;
  localparam logic [7:0] ROP_NOT_D = 8'h0b;
  localparam logic [7:0] ROP_S_XOR_D = 8'h59;
  localparam logic [7:0] ROP_S_NAND_D = 8'hda;
  localparam logic [7:0] ROP_S_AND_D = 8'h05;
  localparam logic [7:0] ROP_S_XNOR_D = 8'h95;
  localparam logic [7:0] ROP_DEST = 8'h06;
  localparam logic [7:0] ROP_NS_OR_D = 8'hd6;
  localparam logic [7:0] ROP_SRC = 8'h0d;
  localparam logic [7:0] ROP_S_OR_ND = 8'had;
  localparam logic [7:0] ROP_S_OR_D = 8'h6d;
  localparam logic [7:0] ROP_ONES = 8'h0e;

  typedef enum logic [1:0] {
    BLTC_IDLE = 2'b00,
    BLTC_RUN = 2'b01,
    BLTC_PAUSE = 2'b10
  } bltc_state_t;

endpackage

// ---- design/bltc_rop.sv ----
// Two-operand raster-operation unit, purely combinational
// Assumes operand and destination are presented in the same cycle
`timescale 1ns/1ps
module bltc_rop (
  input wire logic [7:0] op_i,
  input wire logic [15:0] src_i,
  input wire logic [15:0] dst_i,
  output logic [15:0] res_o
);

  always_comb begin
    case (op_i)
      bltc_pkg::ROP_ZERO: res_o = 16'h0000;
      bltc_pkg::ROP_ONES: res_o = 16'hffff;
      bltc_pkg::ROP_SRC: res_o = src_i;
      bltc_pkg::ROP_S_AND_D: res_o = src_i & dst_i;
      bltc_pkg::ROP_S_OR_D: res_o = src_i | dst_i;
      bltc_pkg::ROP_S_XOR_D: res_o = src_i ^ dst_i;
      bltc_pkg::ROP_NOT_D: res_o = ~dst_i;
      bltc_pkg::ROP_NOT_S: res_o = ~src_i;
      bltc_pkg::ROP_DEST: res_o = dst_i;
      bltc_pkg::ROP_S_AND_ND: res_o = src_i & ~dst_i;
      bltc_pkg::ROP_NS_AND_ND: res_o = ~src_i & ~dst_i;
      bltc_pkg::ROP_NS_AND_D: res_o = ~src_i & dst_i;
      bltc_pkg::ROP_S_XNOR_D: res_o = ~(src_i ^ dst_i);
      bltc_pkg::ROP_S_NAND_D: res_o = ~(src_i & dst_i);
      bltc_pkg::ROP_NS_OR_D: res_o = ~src_i | dst_i;
      bltc_pkg::ROP_S_OR_ND: res_o = src_i | ~dst_i;
      // Unlisted codes leave the destination as it was
      default: res_o = dst_i;
    endcase
  end

endmodule

// ---- design/bltc_tcmp.sv ----
// Transparent-color compare under a per-bit don't-care mask
// Assumes the result word and setup registers share one clock
`timescale 1ns/1ps
module bltc_tcmp (
  input wire logic [15:0] pix_i,
  input wire logic [15:0] color_i,
  input wire logic [15:0] mask_i,
  input wire logic enable_i,
  input wire logic wide_i,
  output logic skip_o
);

  logic [15:0] diff;
  logic match;

  // Masked bits never count as a difference
  assign diff = (pix_i ^ color_i) & ~mask_i;
  // Narrow pixels look at the low byte only
  assign match = wide_i ? (diff == 16'h0000) : (diff[7:0] == 8'h00);
  assign skip_o = enable_i & match;

endmodule

// ---- design/bltc_core.sv ----
// Block-transfer control core: indexed registers, run/suspend engine,
// raster-operation combine and transparency suppression.
// Assumes host port, memory arbiter and pixel path share core_clk_i.
//
// Behaviour
// - Progress flag set at start, cleared at end
// - Progress stays set paused; reset clears it
// - Reset bit aborts engine; no later resume
// - Start runs on free cycle, clears when done
// - Start written zero pauses at line end
// - Paused line count shows remaining lines
// - Start written one resumes where stopped
// - Busy reads one while running, else zero
// - Eight-bit code picks two-operand function
// - Codes 0D source, 00 zeros, 0E ones
// - Codes 05 AND, 6D OR, 59 XOR
// - Codes 0B not dest, D0 not source, 06 dest
// - Codes 09, 90, 50 mixed AND forms
// - Codes 95 XNOR, DA NAND, D6, AD OR forms
// - Equal transparent result is not written
// - Mask ones drop bits from compare
// - Compare only when mode bit 3 set
// - Mode width bit picks 16 or 8 bits
`timescale 1ns/1ps
module bltc_core (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic [15:0] xfer_width_i,
  input wire logic [15:0] xfer_height_i,
  input wire logic mem_free_i,
  input wire logic [15:0] src_pix_i,
  input wire logic [15:0] pat_pix_i,
  input wire logic [15:0] dst_pix_i,
  output logic pix_take_o,
  output logic dst_wr_o,
  output logic [15:0] dst_data_o,
  output logic [15:0] lines_left_o,
  output logic [15:0] pix_left_o,
  output logic busy_o,
  output logic progress_o
);

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] mode;
    logic [7:0] rop;
    logic [15:0] tcol;
    logic [15:0] tmsk;
    logic start;
    logic busy;
    logic prog;
    bltc_pkg::bltc_state_t st;
    logic [15:0] px;
    logic [15:0] ln;
    logic wr;
    logic [15:0] wdat;
    logic [7:0] rdat;
  } bltc_core_st_t;

  localparam bltc_core_st_t RST_STATE = '{
    idx: bltc_pkg::RST_BYTE,
    mode: bltc_pkg::RST_BYTE,
    rop: bltc_pkg::RST_BYTE,
    tcol: bltc_pkg::RST_WORD,
    tmsk: bltc_pkg::RST_WORD,
    start: 1'b0,
    busy: 1'b0,
    prog: 1'b0,
    st: bltc_pkg::BLTC_IDLE,
    px: bltc_pkg::RST_WORD,
    ln: bltc_pkg::RST_WORD,
    wr: 1'b0,
    wdat: bltc_pkg::RST_WORD,
    rdat: bltc_pkg::RST_BYTE
  };

  bltc_core_st_t state_r;
  bltc_core_st_t state_nxt;

  logic step;
  logic use_pattern;
  logic [15:0] operand;
  logic [15:0] rop_res;
  logic skip;
  logic line_end;
  logic last_line;
  logic [7:0] ctrl_view;
  logic [7:0] data_view;

  // A count of zero behaves as one, so both end the walk
  function automatic logic is_final(input logic [15:0] cnt);
    begin
      is_final = (cnt <= 16'h0001);
    end
  endfunction

  // Counters stop at zero rather than wrapping
  function automatic logic [15:0] count_down(input logic [15:0] cnt);
    begin
      if (cnt == 16'h0000) begin
        count_down = 16'h0000;
      end else begin
        count_down = cnt - 16'h0001;
      end
    end
  endfunction

  // Status byte; the reset bit always reads back as zero
  function automatic logic [7:0] pack_ctrl(
    input logic busy,
    input logic start,
    input logic prog
  );
    begin
      pack_ctrl = 8'h00;
      pack_ctrl[bltc_pkg::CTRL_BUSY_BIT] = busy;
      pack_ctrl[bltc_pkg::CTRL_START_BIT] = start;
      pack_ctrl[bltc_pkg::CTRL_PROGRESS_BIT] = prog;
    end
  endfunction

  // Fresh transfer: load both counters and raise the flags
  function automatic bltc_core_st_t launch_engine(
    input bltc_core_st_t s,
    input logic [15:0] width,
    input logic [15:0] height
  );
    begin
      launch_engine = s;
      launch_engine.px = width;
      launch_engine.ln = height;
      launch_engine.st = bltc_pkg::BLTC_RUN;
      launch_engine.busy = 1'b1;
      launch_engine.prog = 1'b1;
    end
  endfunction

  // Last pixel of the last line: back to idle, flags down
  function automatic bltc_core_st_t finish_engine(
    input bltc_core_st_t s
  );
    begin
      finish_engine = s;
      finish_engine.ln = 16'h0000;
      finish_engine.st = bltc_pkg::BLTC_IDLE;
      finish_engine.start = 1'b0;
      finish_engine.busy = 1'b0;
      finish_engine.prog = 1'b0;
    end
  endfunction

  // Abort drops all position state, so no resume
  function automatic bltc_core_st_t abort_engine(
    input bltc_core_st_t s
  );
    begin
      abort_engine = s;
      abort_engine.st = bltc_pkg::BLTC_IDLE;
      abort_engine.px = 16'h0000;
      abort_engine.ln = 16'h0000;
      abort_engine.wr = 1'b0;
      abort_engine.prog = 1'b0;
      abort_engine.start = 1'b0;
      abort_engine.busy = 1'b0;
    end
  endfunction

  // One pixel per granted memory cycle while running
  assign step = (state_r.st == bltc_pkg::BLTC_RUN) && mem_free_i;
  assign line_end = is_final(state_r.px);
  assign last_line = is_final(state_r.ln);

  // Pattern copy swaps the pattern in as first operand
  assign use_pattern = state_r.mode[bltc_pkg::MODE_PATTERN_BIT];
  assign operand = use_pattern ? pat_pix_i : src_pix_i;

  bltc_rop u_rop (
    .op_i(state_r.rop),
    .src_i(operand),
    .dst_i(dst_pix_i),
    .res_o(rop_res)
  );

  bltc_tcmp u_tcmp (
    .pix_i(rop_res),
    .color_i(state_r.tcol),
    .mask_i(state_r.tmsk),
    .enable_i(state_r.mode[bltc_pkg::MODE_TCMP_EN_BIT]),
    .wide_i(state_r.mode[bltc_pkg::MODE_TCMP_WIDE_BIT]),
    .skip_o(skip)
  );

  assign ctrl_view = pack_ctrl(state_r.busy, state_r.start,
    state_r.prog);

  // Data-port read mux; unmapped indices read zero
  always_comb begin
    case (state_r.idx)
      bltc_pkg::IDX_TRANSFER_MODE: begin
        data_view = state_r.mode;
      end
      bltc_pkg::IDX_CTRL_STATUS: begin
        data_view = ctrl_view;
      end
      bltc_pkg::IDX_ROP_SELECT: begin
        data_view = state_r.rop;
      end
      bltc_pkg::IDX_TCOLOR_LOW: begin
        data_view = state_r.tcol[7:0];
      end
      bltc_pkg::IDX_TCOLOR_HIGH: begin
        data_view = state_r.tcol[15:8];
      end
      bltc_pkg::IDX_TMASK_LOW: begin
        data_view = state_r.tmsk[7:0];
      end
      bltc_pkg::IDX_TMASK_HIGH: begin
        data_view = state_r.tmsk[15:8];
      end
      default: begin
        data_view = 8'h00;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.wr = 1'b0;

    // Engine progress
    case (state_r.st)
      bltc_pkg::BLTC_IDLE: begin
        state_nxt.busy = 1'b0;
      end
      bltc_pkg::BLTC_RUN: begin
        if (step) begin
          // Suppressed pixels still consume their memory slot
          state_nxt.wr = ~skip;
          state_nxt.wdat = rop_res;
          if (line_end) begin
            state_nxt.px = xfer_width_i;
            if (last_line) begin
              state_nxt = finish_engine(state_nxt);
            end else begin
              // Line count only drops on a finished line
              state_nxt.ln = count_down(state_r.ln);
              if (!state_r.start) begin
                state_nxt.st = bltc_pkg::BLTC_PAUSE;
                state_nxt.busy = 1'b0;
                state_nxt.prog = 1'b1;
              end
            end
          end else begin
            state_nxt.px = count_down(state_r.px);
          end
        end
      end
      bltc_pkg::BLTC_PAUSE: begin
        state_nxt.busy = 1'b0;
        state_nxt.prog = 1'b1;
      end
      default: begin
        state_nxt.st = bltc_pkg::BLTC_IDLE;
        state_nxt.busy = 1'b0;
        state_nxt.prog = 1'b0;
        state_nxt.start = 1'b0;
      end
    endcase

    // Host writes act on the state the engine is moving to
    if (io_wr_i) begin
      if (!io_addr_i) begin
        state_nxt.idx = io_wdata_i;
      end else begin
        case (state_r.idx)
          bltc_pkg::IDX_TRANSFER_MODE: begin
            state_nxt.mode = io_wdata_i;
          end
          bltc_pkg::IDX_ROP_SELECT: begin
            state_nxt.rop = io_wdata_i;
          end
          bltc_pkg::IDX_TCOLOR_LOW: begin
            state_nxt.tcol[7:0] = io_wdata_i;
          end
          bltc_pkg::IDX_TCOLOR_HIGH: begin
            state_nxt.tcol[15:8] = io_wdata_i;
          end
          bltc_pkg::IDX_TMASK_LOW: begin
            state_nxt.tmsk[7:0] = io_wdata_i;
          end
          bltc_pkg::IDX_TMASK_HIGH: begin
            state_nxt.tmsk[15:8] = io_wdata_i;
          end
          bltc_pkg::IDX_CTRL_STATUS: begin
            if (io_wdata_i[bltc_pkg::CTRL_RESET_BIT]) begin
              state_nxt = abort_engine(state_nxt);
            end else if (io_wdata_i[bltc_pkg::CTRL_START_BIT]) begin
              state_nxt.start = 1'b1;
              if (state_nxt.st == bltc_pkg::BLTC_IDLE) begin
                state_nxt = launch_engine(state_nxt, xfer_width_i,
                  xfer_height_i);
              end else if (state_nxt.st == bltc_pkg::BLTC_PAUSE) begin
                // Counters were kept, so the walk continues
                state_nxt.st = bltc_pkg::BLTC_RUN;
                state_nxt.busy = 1'b1;
              end
            end else begin
              // Clearing start is a request, honoured at line end
              state_nxt.start = 1'b0;
            end
          end
          default: begin
            state_nxt.idx = state_r.idx;
          end
        endcase
      end
    end

    // Read data is captured one cycle after the strobe
    if (io_rd_i) begin
      state_nxt.rdat = io_addr_i ? data_view : state_r.idx;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_r <= RST_STATE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  assign pix_take_o = step & ce_i;
  assign dst_wr_o = state_r.wr;
  assign dst_data_o = state_r.wdat;
  assign io_rdata_o = state_r.rdat;
  assign lines_left_o = state_r.ln;
  assign pix_left_o = state_r.px;
  assign busy_o = state_r.busy;
  assign progress_o = state_r.prog;

endmodule

// ---- bench/bltc_core_assertions.sv ----
// Port checker for the block-transfer control core
// Assumes it is bound to bltc_core on its single clock
`timescale 1ns/1ps
module bltc_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic io_wr_i,
  input wire logic io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic mem_free_i,
  input wire logic pix_take_o,
  input wire logic dst_wr_o,
  input wire logic [15:0] dst_data_o,
  input wire logic [15:0] lines_left_o,
  input wire logic busy_o,
  input wire logic progress_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [7:0] idx_r;
  logic cw;
  // Data write aimed at the control/status index
  assign cw = ce_i && io_wr_i && io_addr_i
    && idx_r == bltc_pkg::IDX_CTRL_STATUS;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      idx_r <= 8'h00;
    end else if (ce_i && io_wr_i && !io_addr_i) begin
      idx_r <= io_wdata_i;
    end
  end
  a_take_needs_run: assert property (
    pix_take_o |-> mem_free_i && ce_i && busy_o)
    else $error("pixel taken while not running");
  a_write_after_take: assert property (
    dst_wr_o && $past(ce_i) |-> $past(pix_take_o))
    else $error("destination write without a take");
  a_result_holds: assert property (
    !pix_take_o |=> $stable(dst_data_o))
    else $error("result changed without a take");
  a_busy_has_progress: assert property (
    busy_o |-> progress_o)
    else $error("busy without progress");
  a_start_runs: assert property (
    cw && io_wdata_i[1] && !io_wdata_i[2] |=> busy_o && progress_o)
    else $error("start write did not run the engine");
  a_reset_idles: assert property (
    cw && io_wdata_i[2] |=> !busy_o && !progress_o && !dst_wr_o)
    else $error("engine reset did not idle the engine");
  a_pause_holds: assert property (
    progress_o && !busy_o && !io_wr_i |=> progress_o)
    else $error("progress dropped while paused");
  a_pause_lines: assert property (
    progress_o && !busy_o |-> lines_left_o != 16'h0000)
    else $error("paused with no lines left");
endmodule

bind bltc_core bltc_chk i_chk (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .ce_i(ce_i), .io_wr_i(io_wr_i),
  .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
  .mem_free_i(mem_free_i), .pix_take_o(pix_take_o),
  .dst_wr_o(dst_wr_o), .dst_data_o(dst_data_o),
  .lines_left_o(lines_left_o), .busy_o(busy_o),
  .progress_o(progress_o));

// ---- bench/blit_engine_control_rop_bench.sv ----
// Self-checking bench for the block-transfer control core
// Assumes a 250 MHz clock and a synchronous active-low reset
`timescale 1ns/1ps
module blit_engine_control_rop_bench;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic io_addr_i = 1'b0;
  logic mem_free = 1'b0;
  logic hold = 1'b0;
  logic pend = 1'b0;
  logic exw = 1'b0;
  logic ce = 1'b1;
  logic frz = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] rdata, m_code, m_mode;
  logic [15:0] xw = 16'h0003, xh = 16'h0002;
  logic [15:0] src = 16'h0000, pat = 16'h0000, dst = 16'h0000;
  logic [15:0] tc = 16'h0000, tm = 16'h0000, ex, ddata, lines, pleft;
  logic take, dwr, busy, prog;
  integer errors = 0, n_compared = 0, seed = 49048, takes = 0;
  always #2 core_clk_i = ~core_clk_i;
  bltc_core i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(rdata), .xfer_width_i(xw), .xfer_height_i(xh),
    .mem_free_i(mem_free), .src_pix_i(src), .pat_pix_i(pat),
    .dst_pix_i(dst), .pix_take_o(take), .dst_wr_o(dwr),
    .dst_data_o(ddata), .lines_left_o(lines), .pix_left_o(pleft),
    .busy_o(busy), .progress_o(prog));
  task chk(input string nm, input logic [15:0] seen, want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask
  function logic [15:0] rop(input logic [7:0] c, logic [15:0] s, d);
    case (c)
      8'h0d: rop = s;
      8'h00: rop = 16'h0000;
      8'h0e: rop = 16'hffff;
      8'h05: rop = s & d;
      8'h6d: rop = s | d;
      8'h59: rop = s ^ d;
      8'h0b: rop = ~d;
      8'hd0: rop = ~s;
      8'h09: rop = s & ~d;
      8'h90: rop = ~s & ~d;
      8'h50: rop = ~s & d;
      8'h95: rop = ~(s ^ d);
      8'hda: rop = ~(s & d);
      8'hd6: rop = ~s | d;
      8'had: rop = s | ~d;
      default: rop = d;
    endcase
  endfunction
  // Pixel model: a take at an edge predicts the write seen after it
  always @(posedge core_clk_i) begin
    pend = take && rst_n_i;
    if (pend) begin
      takes++;
      ex = rop(m_code, m_mode[6] ? pat : src, dst);
      exw = !(m_mode[3] && ((ex ^ tc) & ~tm
        & (m_mode[4] ? 16'hffff : 16'h00ff)) == 16'h0000);
    end
  end
  always @(negedge core_clk_i) begin
    if (pend) begin
      chk("dst_wr_o", 16'(dwr), 16'(exw));
      chk("dst_data_o", ddata, ex);
    end
    ce = !frz || 1'($random(seed));
    mem_free = hold ? 1'b0 : 1'($random(seed));
    src = ($random(seed) & 1) ? tc : 16'($random(seed));
    pat = 16'($random(seed));
    dst = 16'($random(seed));
  end
  task idx(input logic [7:0] i);
    @(negedge core_clk_i);
    io_wr_i = 1'b1;
    io_addr_i = 1'b0;
    io_wdata_i = i;
    @(negedge core_clk_i);
    io_wr_i = 1'b0;
  endtask
  task wr(input logic [7:0] i, d);
    idx(i);
    @(negedge core_clk_i);
    io_wr_i = 1'b1;
    io_addr_i = 1'b1;
    io_wdata_i = d;
    @(negedge core_clk_i);
    io_wr_i = 1'b0;
  endtask
  task rd(input logic [7:0] i, output logic [7:0] d);
    idx(i);
    @(negedge core_clk_i);
    io_rd_i = 1'b1;
    io_addr_i = 1'b1;
    @(negedge core_clk_i);
    io_rd_i = 1'b0;
    d = rdata;
  endtask
  // Zero waits for busy low (idle or paused), otherwise for that many takes
  task wt(input int k);
    int n;
    n = 0;
    frz = 1'b1;
    @(negedge core_clk_i);
    while ((k == 0 ? busy !== 1'b0 : takes < k) && n < 900) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 900) begin
      errors++;
      wrap_up();
    end
    frz = 1'b0;
    @(negedge core_clk_i);
  endtask
  task wrap_up();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] r, v;
    logic [7:0] ra [7] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35,
      8'h38, 8'h39};
    logic [7:0] cs [16] = '{8'h00, 8'h90, 8'h50, 8'hd0, 8'h09,
      8'h0b, 8'h59, 8'hda, 8'h05, 8'h95, 8'h06, 8'hd6, 8'h0d,
      8'had, 8'h6d, 8'h0e};
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    foreach (ra[k]) begin
      rd(ra[k], r);
      chk("reset value", 16'(r), 16'h0000);
      v = 8'($random(seed)) & 8'hf9;
      if (k != 1) wr(ra[k], v);
      if (k != 1) rd(ra[k], r);
      if (k != 1) chk("readback", 16'(r), 16'(v));
    end
    wr(8'h33, 8'hff);
    rd(8'h33, r);
    chk("unmapped", 16'(r), 16'h0000);
    idx(8'h32);
    @(negedge core_clk_i);
    io_rd_i = 1'b1;
    io_addr_i = 1'b0;
    @(negedge core_clk_i);
    io_rd_i = 1'b0;
    chk("index readback", 16'(rdata), 16'h0032);
    v = 8'($random(seed));
    tc = {v, v};
    wr(8'h34, v);
    wr(8'h35, v);
    v = 8'($random(seed) | $random(seed));
    tm = {v, v};
    wr(8'h38, v);
    wr(8'h39, v);
    foreach (cs[k]) begin
      m_mode = {1'b0, k[0], 1'b0, k[1], k[2], 3'b000};
      m_code = cs[k];
      wr(8'h30, m_mode);
      wr(8'h32, m_code);
      takes = 0;
      wr(8'h31, 8'h02);
      wt(0);
      chk("takes", 16'(takes), xw * xh);
      rd(8'h31, r);
      chk("status", 16'(r), 16'h0000);
    end
    xw = 16'h0004;
    xh = 16'h0003;
    takes = 0;
    wr(8'h31, 8'h02);
    wt(2);
    wr(8'h31, 8'h00);
    wt(0);
    chk("pause at line end", 16'(takes % 4), 16'h0000);
    chk("lines_left_o", lines, 16'(3 - takes / 4));
    chk("pix_left_o", pleft, xw);
    rd(8'h31, r);
    chk("paused status", 16'(r), 16'h0008);
    wr(8'h31, 8'h02);
    wt(0);
    chk("resumed takes", 16'(takes), 16'h000c);
    takes = 0;
    wr(8'h31, 8'h02);
    wt(2);
    hold = 1'b1;
    wr(8'h31, 8'h06);
    hold = 1'b0;
    chk("progress_o", 16'(prog), 16'h0000);
    chk("lines_left_o", lines, 16'h0000);
    rd(8'h31, r);
    chk("after engine reset", 16'(r), 16'h0000);
    takes = 0;
    wr(8'h31, 8'h02);
    wt(0);
    chk("fresh takes", 16'(takes), 16'h000c);
    takes = 0;
    wr(8'h31, 8'h02);
    wt(2);
    rst_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    @(negedge core_clk_i);
    chk("busy_o", 16'(busy), 16'h0000);
    chk("progress_o", 16'(prog), 16'h0000);
    chk("lines_left_o", lines, 16'h0000);
    rd(8'h32, r);
    chk("rop after reset", 16'(r), 16'h0000);
    wrap_up();
  end
endmodule
